//--- hw/sasio_defines.svh
/*
 Constants of the smoke alarm sequencer: register offsets, reset values,
 field positions and slot positions counted in oscillator periods.
 Assumes a 12-bit free-running oscillator period counter.
*/
`ifndef SASIO_DEFINES_SVH
`define SASIO_DEFINES_SVH

// Register offsets (byte addresses, 4-bit address port)
`define SASIO_ADDR_CTRL 4'h0
`define SASIO_ADDR_STATUS 4'h4
`define SASIO_ADDR_IRQ_STAT 4'h8
`define SASIO_ADDR_IRQ_MASK 4'hC

// Control fields and reset values
`define SASIO_CTRL_HORN_EN 0
`define SASIO_CTRL_IO_EN 1
`define SASIO_CTRL_RESET 2'h3
`define SASIO_IRQ_MASK_RESET 3'h0

// Interrupt status bit positions
`define SASIO_EV_LOCAL 0
`define SASIO_EV_REMOTE 1
`define SASIO_EV_TROUBLE 2

// Slot masks and offsets in oscillator periods
`define SASIO_SMOKE_MASK 12'h3FF
`define SASIO_CHAMBER_MASK 12'hFFF
`define SASIO_BUTTON_MASK 12'h01F
`define SASIO_SAMPLE_MASK 12'h03F
`define SASIO_LED_ALARM_MASK 12'h03F
`define SASIO_LED_OFS 12'h010
`define SASIO_CHIRP_OFS 12'h820
`define SASIO_MOD_MASK 12'h01F
`define SASIO_MOD_OFF 12'h008

// Core-clock timing
`define SASIO_IO_GUARD 2'h3
`define SASIO_TONE_HALF 16'h1F81

`endif

//--- hw/sasio_pkg.sv
/*
 Types of the smoke alarm sequencer.
 Assumes the constants of sasio_defines.svh.
*/
package sasio_pkg;

   typedef enum logic [3:0] {
      SASIO_ST_STANDBY = 4'h1,
      SASIO_ST_REMOTE = 4'h2,
      SASIO_ST_SMOKE = 4'h4,
      SASIO_ST_TEST = 4'h8
   } sasio_state_t;

   typedef struct packed {
      logic osc_s1;
      logic osc_s2;
      logic osc_d;
      logic tick;
      logic [11:0] cnt;
   } sasio_tick_st_t;

   typedef struct packed {
      logic [4:0] sy1;
      logic [4:0] sy2;
      sasio_state_t state;
      logic [1:0] ctrl;
      logic [2:0] irq_stat;
      logic [2:0] irq_mask;
      logic [7:0] rdata;
      logic edge_flag;
      logic io_prev;
      logic [1:0] guard;
      logic remote;
      logic trouble_d;
      logic tone;
      logic [15:0] tone_cnt;
      logic emitter;
      logic strobe;
      logic led;
      logic metal;
      logic ceramic;
      logic io_drive;
      logic irq;
   } sasio_st_t;

endpackage

//--- hw/sasio_tick_if.sv
/*
 Oscillator timebase bundle passed from the period counter to the sequencer.
 Assumes both ends run on core_clk_i.
*/
`timescale 1ns/1ns
interface sasio_tick_if;
   logic tick;
   logic osc_low;
   logic [11:0] cnt;
   modport src (output tick, output osc_low, output cnt);
   modport dst (input tick, input osc_low, input cnt);
endinterface

//--- hw/sasio_tick.sv
/*
 Oscillator period counter: synchronises the RC oscillator pin, marks each
 period start (rising edge) and counts periods freely.
 Assumes the oscillator is far slower than core_clk_i.
*/
`timescale 1ns/1ns
`include "sasio_defines.svh"
module sasio_tick
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Oscillator pin
   input wire logic osc_i,
   // Timebase out
   sasio_tick_if.src tif
);
   sasio_pkg::sasio_tick_st_t s;
   sasio_pkg::sasio_tick_st_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.osc_s1 = osc_i;
      next_s.osc_s2 = s.osc_s1;
      next_s.osc_d = s.osc_s2;
      next_s.tick = s.osc_s2 & ~s.osc_d;
      if (s.tick)
      begin
         next_s.cnt = s.cnt + 12'h001;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign tif.tick = s.tick;
   assign tif.osc_low = ~s.osc_d;
   assign tif.cnt = s.cnt;

   count_step_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      tif.tick |=> tif.cnt == $past(tif.cnt) + 12'h001)
      else $error("period counter did not advance on a period start");

endmodule // sasio_tick

//--- hw/sasio_top.sv
/*
 Smoke alarm sequencer: times emitter, strobe, indicator and horn against the
 oscillator period, handles the wired-OR interconnect and the register port.
 Assumes analog conditions and pins are asynchronous and are synchronised here;
 the pad turns io_oe_o into current sourcing and supplies the sink.
*/
//
// Contract
// - Emitter pulse lasts one oscillator low phase
// - No emitter while indicator or horn active
// - Emitter pulse falls at strobe end
// - Interconnect is wired-OR, sourced high only
// - Rising edges latched, flag sampled periodically
// - Source interconnect on local smoke or test
// - Ignore interconnect input while sourcing it
// - Reset disables interconnect drive
// - Smoke alarm: continuous modulated horn tone
// - Trouble: single short horn chirp only
// - Horn halves driven complementary when sounding
// - Emitter every 1024, 4096, 32 periods
// - Smoke modulation on three quarters of period
// - Chirp each 4096 periods, one period long
// - Remote edge starts alarm within 800 ms
`timescale 1ns/1ns
`include "sasio_defines.svh"
module sasio_top
#(
   parameter logic [15:0] TONE_HALF = `SASIO_TONE_HALF
)
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Oscillator and analog conditions
   input wire logic osc_i,
   input wire logic local_smoke_i,
   input wire logic button_test_i,
   input wire logic low_supply_i,
   input wire logic chamber_degraded_i,
   // Interconnect pin
   input wire logic io_i,
   output logic io_o,
   output logic io_oe_o,
   // Emitter, strobe, indicator, horn
   output logic infrared_emitter_drive_o,
   output logic strobe_o,
   output logic led_n_o,
   output logic led_oe_o,
   output logic horn_metal_o,
   output logic horn_ceramic_o,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Interrupt
   output logic irq_o
);
   if (TONE_HALF < 16'h0002)
   begin : g_bad_tone
      $error("TONE_HALF must be at least 2");
   end

   sasio_tick_if tif ();

   sasio_tick u_tick
   (
      .core_clk_i (core_clk_i),
      .rstn_i (rstn_i),
      .osc_i (osc_i),
      .tif (tif)
   );

   sasio_pkg::sasio_st_t s;
   sasio_pkg::sasio_st_t next_s;
   logic local_smoke;
   logic button;
   logic trouble;
   logic io_lvl;
   logic block_in;
   logic sample;
   logic strobe_slot;
   logic led_slot;
   logic mod_on;
   logic chirp;
   logic horn_on;
   logic [2:0] ev;

   always_comb
   begin
      next_s = s;
      next_s.sy1 = {io_i, chamber_degraded_i, low_supply_i, button_test_i, local_smoke_i};
      next_s.sy2 = s.sy1;
      local_smoke = s.sy2[0];
      button = s.sy2[1];
      trouble = s.sy2[2] | s.sy2[3];
      io_lvl = s.sy2[4];

      // Own drive decays through the sync stages, so keep ignoring briefly after release
      block_in = s.io_drive | (s.guard != 2'h0);
      sample = tif.tick & ((tif.cnt & `SASIO_SAMPLE_MASK) == 12'h000);
      next_s.guard = s.io_drive ? `SASIO_IO_GUARD : (s.guard != 2'h0 ? s.guard - 2'h1 : 2'h0);
      next_s.io_prev = io_lvl;
      if (sample)
      begin
         next_s.edge_flag = 1'b0;
         next_s.remote = s.edge_flag | (s.remote & io_lvl);
      end
      if (io_lvl & ~s.io_prev)
      begin
         next_s.edge_flag = 1'b1;
      end
      if (block_in)
      begin
         next_s.edge_flag = 1'b0;
         next_s.remote = 1'b0;
      end

      if (button)
      begin
         next_s.state = sasio_pkg::SASIO_ST_TEST;
      end
      else if (local_smoke)
      begin
         next_s.state = sasio_pkg::SASIO_ST_SMOKE;
      end
      else if (s.remote)
      begin
         next_s.state = sasio_pkg::SASIO_ST_REMOTE;
      end
      else
      begin
         next_s.state = sasio_pkg::SASIO_ST_STANDBY;
      end

      // Drive only from a settled state, never straight out of reset
      next_s.io_drive = s.ctrl[`SASIO_CTRL_IO_EN] & ((s.state == sasio_pkg::SASIO_ST_SMOKE) |
                        (s.state == sasio_pkg::SASIO_ST_TEST));

      strobe_slot = 1'b0;
      led_slot = 1'b0;
      mod_on = 1'b0;
      chirp = 1'b0;
      unique case (s.state)
         sasio_pkg::SASIO_ST_TEST:
         begin
            strobe_slot = (tif.cnt & `SASIO_BUTTON_MASK) == 12'h000;
            led_slot = (tif.cnt & `SASIO_LED_ALARM_MASK) == `SASIO_LED_OFS;
         end
         sasio_pkg::SASIO_ST_SMOKE:
         begin
            strobe_slot = (tif.cnt & `SASIO_SMOKE_MASK) == 12'h000;
            led_slot = (tif.cnt & `SASIO_LED_ALARM_MASK) == `SASIO_LED_OFS;
            mod_on = (tif.cnt & `SASIO_MOD_MASK) >= `SASIO_MOD_OFF;
         end
         sasio_pkg::SASIO_ST_REMOTE:
         begin
            strobe_slot = (tif.cnt & `SASIO_SMOKE_MASK) == 12'h000;
            mod_on = (tif.cnt & `SASIO_MOD_MASK) >= `SASIO_MOD_OFF;
         end
         sasio_pkg::SASIO_ST_STANDBY:
         begin
            // Chamber test slots every 4096 coincide with smoke slots every 1024
            strobe_slot = ((tif.cnt & `SASIO_SMOKE_MASK) == 12'h000) |
                          ((tif.cnt & `SASIO_CHAMBER_MASK) == 12'h000);
            led_slot = tif.cnt == `SASIO_LED_OFS;
            chirp = trouble & (tif.cnt == `SASIO_CHIRP_OFS);
         end
      endcase
      horn_on = s.ctrl[`SASIO_CTRL_HORN_EN] & (mod_on | chirp);

      if (horn_on)
      begin
         if (s.tone_cnt >= TONE_HALF - 16'h0001)
         begin
            next_s.tone_cnt = 16'h0000;
            next_s.tone = ~s.tone;
         end
         else
         begin
            next_s.tone_cnt = s.tone_cnt + 16'h0001;
         end
      end
      else
      begin
         next_s.tone_cnt = 16'h0000;
         next_s.tone = 1'b0;
      end
      next_s.metal = horn_on & s.tone;
      next_s.ceramic = horn_on & ~s.tone;
      next_s.led = led_slot;
      next_s.strobe = strobe_slot;
      // High phase is long, low phase short: the low phase sits at the strobe's end
      next_s.emitter = strobe_slot & tif.osc_low & ~led_slot & ~horn_on;

      ev = '0;
      ev[`SASIO_EV_LOCAL] = (next_s.state == sasio_pkg::SASIO_ST_SMOKE) &
                            (s.state != sasio_pkg::SASIO_ST_SMOKE);
      ev[`SASIO_EV_REMOTE] = (next_s.state == sasio_pkg::SASIO_ST_REMOTE) &
                             (s.state != sasio_pkg::SASIO_ST_REMOTE);
      ev[`SASIO_EV_TROUBLE] = trouble & ~s.trouble_d;
      next_s.trouble_d = trouble;

      next_s.rdata = 8'h00;
      if (wr_i)
      begin
         unique case (addr_i)
            `SASIO_ADDR_CTRL: next_s.ctrl = wdata_i[1:0];
            `SASIO_ADDR_IRQ_STAT: next_s.irq_stat = s.irq_stat & ~wdata_i[2:0];
            `SASIO_ADDR_IRQ_MASK: next_s.irq_mask = wdata_i[2:0];
            default: next_s.ctrl = s.ctrl;
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      next_s.irq_stat = next_s.irq_stat | ev;
      if (rd_i)
      begin
         unique case (addr_i)
            `SASIO_ADDR_CTRL: next_s.rdata = {6'h00, s.ctrl};
            `SASIO_ADDR_STATUS: next_s.rdata = {2'h0, s.edge_flag, trouble, s.state};
            `SASIO_ADDR_IRQ_STAT: next_s.rdata = {5'h00, s.irq_stat};
            `SASIO_ADDR_IRQ_MASK: next_s.rdata = {5'h00, s.irq_mask};
            default: next_s.rdata = 8'h00;
         endcase
      end
      next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         s <= '0;
         s.state <= sasio_pkg::SASIO_ST_STANDBY;
         s.ctrl <= `SASIO_CTRL_RESET;
         s.irq_mask <= `SASIO_IRQ_MASK_RESET;
         s.io_drive <= 1'b0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign io_o = s.io_drive;
   assign io_oe_o = s.io_drive;
   assign infrared_emitter_drive_o = s.emitter;
   assign strobe_o = s.strobe;
   assign led_n_o = 1'b0;
   assign led_oe_o = s.led;
   assign horn_metal_o = s.metal;
   assign horn_ceramic_o = s.ceramic;
   assign rdata_o = s.rdata;
   assign irq_o = s.irq;

   emitter_low_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      infrared_emitter_drive_o |-> $past(tif.osc_low))
      else $error("emitter high outside oscillator low phase");

   emitter_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      infrared_emitter_drive_o |-> !led_oe_o && !horn_metal_o && !horn_ceramic_o)
      else $error("emitter active with indicator or horn");

   emitter_strobe_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      infrared_emitter_drive_o |-> strobe_o)
      else $error("emitter outside strobe");

   io_source_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (s.ctrl[`SASIO_CTRL_IO_EN] && s.state == sasio_pkg::SASIO_ST_TEST) |=> io_oe_o && io_o)
      else $error("interconnect not sourced during test");

   io_ignore_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      io_oe_o |=> !s.edge_flag && !s.remote)
      else $error("own drive registered as remote smoke");

   io_reset_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !$past(rstn_i) |-> !io_oe_o ##1 !io_oe_o)
      else $error("interconnect driven right after reset");

   remote_start_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (sample && s.edge_flag && !block_in && !local_smoke && !button) |=> ##1
      s.state == sasio_pkg::SASIO_ST_REMOTE)
      else $error("latched edge did not start remote alarm");

   horn_compl_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (horn_metal_o || horn_ceramic_o) |-> horn_metal_o != horn_ceramic_o)
      else $error("horn halves not complementary");

   mod_gap_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (s.state == sasio_pkg::SASIO_ST_SMOKE && (tif.cnt & `SASIO_MOD_MASK) < `SASIO_MOD_OFF)
      |=> !horn_metal_o && !horn_ceramic_o)
      else $error("horn on during modulation off part");

   trouble_only_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      ($past(s.state) == sasio_pkg::SASIO_ST_STANDBY && (horn_metal_o || horn_ceramic_o))
      |-> $past(tif.cnt) == `SASIO_CHIRP_OFS)
      else $error("trouble horn outside chirp slot");

   button_rate_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (s.state == sasio_pkg::SASIO_ST_TEST && (tif.cnt & `SASIO_BUTTON_MASK) == 12'h000) |=> strobe_o)
      else $error("missing push-button strobe slot");

endmodule // sasio_top

//--- tb/sasio_unit_model.sv
/*
 Model of the other detector units sharing the wired-OR interconnect line.
 Assumes the pad of the unit under test sources high only while its enable is set.
*/
`timescale 1ns/1ns
module sasio_unit_model
#(
   parameter int UNITS = 40
)
(
   // Unit under test
   input wire logic dut_oe_i,
   input wire logic dut_o_i,
   // Remote units, one sourcing request each
   input wire logic [UNITS-1:0] remote_src_i,
   // Resolved line
   output logic line_o
);
   // Nobody sources: the on-chip sink pulls the line low, never a stale high
   assign line_o = (dut_oe_i & dut_o_i) | (|remote_src_i);
endmodule // sasio_unit_model

//--- tb/sasio_top_tb.sv
/*
 Self-checking bench of the smoke alarm sequencer: register port tasks,
 an oscillator pin of 12 core cycles and remote units on the interconnect.
 Assumes sasio_defines.svh on the include path.
*/
`timescale 1ns/1ns
`include "sasio_defines.svh"
module sasio_top_tb;
   localparam int OSC_P = 12;
   localparam int CEIL = 60000;
   logic core_clk_i, rstn_i, osc_i, local_smoke_i, button_test_i, low_supply_i;
   logic io_line, io_o, io_oe_o, emit, strobe_o, led_n_o, led_oe_o, metal, ceramic;
   logic wr_i, rd_i, irq_o, remote_src, chamber_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   int bad_count, cmp_count, cyc, osc_ph, n, w;

   sasio_top #(.TONE_HALF(16'h0004)) i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .osc_i(osc_i),
      .local_smoke_i(local_smoke_i), .button_test_i(button_test_i), .low_supply_i(low_supply_i),
      .chamber_degraded_i(chamber_i), .io_i(io_line), .io_o(io_o), .io_oe_o(io_oe_o),
      .infrared_emitter_drive_o(emit), .strobe_o(strobe_o), .led_n_o(led_n_o), .led_oe_o(led_oe_o),
      .horn_metal_o(metal), .horn_ceramic_o(ceramic), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

   sasio_unit_model i_units (.dut_oe_i(io_oe_o), .dut_o_i(io_o), .remote_src_i({39'h0, remote_src}),
      .line_o(io_line));

   task automatic finish_test();
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return strobe_o;
         1: return emit;
         2: return metal | ceramic;
         3: return io_oe_o;
         5: return led_oe_o;
         default: return irq_o;
      endcase
   endfunction

   // Bounded wait, sampled just after each rising edge
   task automatic wait_sel(input int sel, input logic val, input int lim, output int cnt);
      cnt = 0;
      do
      begin
         @(posedge core_clk_i);
         #1;
         cnt++;
      end
      while (sig(sel) !== val && cnt < lim);
      check("wait_sel", {15'h0, sig(sel)}, {15'h0, val});
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd(input string name, input logic [3:0] a, input logic [7:0] msk, input logic [7:0] exp);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      check(name, {8'h00, rdata_o & msk}, {8'h00, exp});
   endtask

   // Rise to rise of the strobe; aligns on a rise first
   task automatic period(input int lim, input int exp);
      int a;
      int b;
      wait_sel(0, 1'b0, lim, a);
      wait_sel(0, 1'b1, lim, a);
      wait_sel(0, 1'b0, lim, a);
      wait_sel(0, 1'b1, lim, b);
      check("strobe_period", 16'(a + b), 16'(exp));
   endtask

   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // Oscillator: high 7, low 5 core cycles
   always @(posedge core_clk_i)
   begin
      osc_ph <= (osc_ph == OSC_P - 1) ? 0 : osc_ph + 1;
      osc_i <= (osc_ph < 7);
      cyc <= cyc + 1;
      if (rstn_i && emit === 1'b1)
         check("emit_quiet", {15'h0, led_oe_o | metal | ceramic}, 16'h0000);
      if (metal === 1'b1 || ceramic === 1'b1)
         check("horn_pair", {15'h0, metal ^ ceramic}, 16'h0001);
      if (cyc == CEIL)
      begin
         bad_count++;
         finish_test();
      end
   end

   initial
   begin
      {rstn_i, local_smoke_i, button_test_i, low_supply_i, wr_i, rd_i, remote_src, chamber_i} = 8'h00;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      {bad_count, cmp_count} = '0;
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      low_supply_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      check("io_oe_reset", {15'h0, io_oe_o}, 16'h0000);
      rd("ctrl_reset", `SASIO_ADDR_CTRL, 8'hFF, `SASIO_CTRL_RESET);
      rd("mask_reset", `SASIO_ADDR_IRQ_MASK, 8'hFF, {5'h00, `SASIO_IRQ_MASK_RESET});
      rd("status_trouble", `SASIO_ADDR_STATUS, 8'hFF, 8'h11);
      wr(`SASIO_ADDR_CTRL, 8'h01);
      rd("ctrl_rw", `SASIO_ADDR_CTRL, 8'hFF, 8'h01);
      wr(`SASIO_ADDR_CTRL, 8'h03);
      wr(4'h2, 8'hFF);
      rd("unmapped", 4'h2, 8'hFF, 8'h00);
      rd("ctrl_kept", `SASIO_ADDR_CTRL, 8'hFF, 8'h03);
      // Interrupt: raised while masked, unmasked, then cleared by writing one
      rd("irq_stat", `SASIO_ADDR_IRQ_STAT, 8'hFF, 8'h04);
      check("irq_masked", {15'h0, irq_o}, 16'h0000);
      wr(`SASIO_ADDR_IRQ_MASK, 8'h04);
      wait_sel(4, 1'b1, 4, n);
      wr(`SASIO_ADDR_IRQ_STAT, 8'h04);
      wait_sel(4, 1'b0, 4, n);
      rd("irq_clear", `SASIO_ADDR_IRQ_STAT, 8'hFF, 8'h00);
      period(13000, 1024 * OSC_P);
      // Next strobe slot is period 2048; the chirp comes 32 periods later
      wait_sel(2, 1'b1, 500, n);
      wait_sel(2, 1'b0, 20, w);
      check("chirp_len", {15'h0, w >= OSC_P - 1 && w <= OSC_P + 1}, 16'h0001);
      // Degraded chamber alone must also report trouble
      @(posedge core_clk_i);
      low_supply_i <= 1'b0;
      chamber_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      rd("status_chamber", `SASIO_ADDR_STATUS, 8'h10, 8'h10);
      // Remote unit drives the line
      @(posedge core_clk_i);
      chamber_i <= 1'b0;
      remote_src <= 1'b1;
      wait_sel(2, 1'b1, 950, n);
      rd("status_remote", `SASIO_ADDR_STATUS, 8'h0F, 8'h02);
      check("io_oe_remote", {15'h0, io_oe_o}, 16'h0000);
      rd("irq_remote", `SASIO_ADDR_IRQ_STAT, 8'h02, 8'h02);
      n = 0;
      repeat (32 * OSC_P)
      begin
         @(posedge core_clk_i);
         #1;
         n += int'(metal | ceramic);
      end
      check("duty", {15'h0, n >= 281 && n <= 295}, 16'h0001);
      @(posedge core_clk_i);
      remote_src <= 1'b0;
      repeat (2400) @(posedge core_clk_i);
      rd("status_back", `SASIO_ADDR_STATUS, 8'h0F, 8'h01);
      // Local smoke: own drive must not come back as remote smoke
      @(posedge core_clk_i);
      local_smoke_i <= 1'b1;
      wait_sel(3, 1'b1, 20, n);
      check("line_high", {14'h0, io_o, io_line}, 16'h0003);
      rd("status_smoke", `SASIO_ADDR_STATUS, 8'h0F, 8'h04);
      // Indicator flashes once every 64 periods in smoke, sinking through the low data bit
      wait_sel(5, 1'b1, 800, n);
      check("led_drive", {15'h0, led_n_o}, 16'h0000);
      @(posedge core_clk_i);
      local_smoke_i <= 1'b0;
      wait_sel(3, 1'b0, 20, n);
      repeat (2400) @(posedge core_clk_i);
      rd("status_no_echo", `SASIO_ADDR_STATUS, 8'h0F, 8'h01);
      // Push-button test
      @(posedge core_clk_i);
      button_test_i <= 1'b1;
      wait_sel(3, 1'b1, 20, n);
      rd("status_test", `SASIO_ADDR_STATUS, 8'h0F, 8'h08);
      period(400, 32 * OSC_P);
      wait_sel(1, 1'b1, 400, n);
      check("emit_in_strobe", {15'h0, strobe_o}, 16'h0001);
      wait_sel(1, 1'b0, 20, w);
      check("emit_width", {15'h0, w >= 4 && w <= 6}, 16'h0001);
      wait_sel(0, 1'b0, 8, n);
      @(posedge core_clk_i);
      button_test_i <= 1'b0;
      finish_test();
   end
endmodule // sasio_top_tb
